// File: rtl/ipic_top.v
// Purpose: Interprocessor interrupt command register and send handshake.
// Assumes: Software accesses the register as two 32-bit halves; the bus
//          interface accepts one message with a valid/ready handshake.
// Notes:   Newer or older generation handling is a strap input.
`timescale 1ns/1ps
`include "ipic_map.vh"
module ipic_top (
  input  wire        sys_clk_i,
  input  wire        rst_n_i,
  input  wire        clk_en_i,
  input  wire        newer_gen_i,
  input  wire        low_wr_i,
  input  wire        high_wr_i,
  input  wire [31:0] wdata_i,
  input  wire        deep_sleep_i,
  input  wire        bus_ready_i,
  output reg  [31:0] low_rdata_o,
  output reg  [31:0] high_rdata_o,
  output reg         busy_o,
  output reg         msg_valid_o,
  output reg  [7:0]  msg_vector_o,
  output reg  [2:0]  msg_dmode_o,
  output reg         msg_logical_o,
  output reg         msg_level_o,
  output reg         msg_trigger_o,
  output reg  [7:0]  msg_dest_o,
  output reg         msg_self_only_o,
  output reg         msg_excl_self_o,
  output reg         msg_may_return_o
);
  reg  [31:0] low_ff;
  reg  [31:0] high_ff;
  reg         pend_ff;
  reg  [31:0] nxt_low;
  reg         nxt_pend;
  wire [7:0]  c_vec;
  wire [2:0]  c_dm;
  wire        c_log;
  wire        c_lvl;
  wire        c_trg;
  wire [7:0]  c_dst;
  wire        c_self;
  wire        c_excl;
  wire        c_ret;
  wire        accept = msg_valid_o && bus_ready_i;

  // --------------------------------------------------------------------
  // Message composition
  // --------------------------------------------------------------------
  ipic_compose u_compose (
    .newer_gen_i      (newer_gen_i),
    .cmd_i            ({high_ff, nxt_low}),
    .msg_vector_o     (c_vec),
    .msg_dmode_o      (c_dm),
    .msg_logical_o    (c_log),
    .msg_level_o      (c_lvl),
    .msg_trigger_o    (c_trg),
    .msg_dest_o       (c_dst),
    .msg_self_only_o  (c_self),
    .msg_excl_self_o  (c_excl),
    .msg_may_return_o (c_ret)
  );

  // --------------------------------------------------------------------
  // Register update
  // --------------------------------------------------------------------
  always @* begin
    nxt_low = low_ff;
    if (deep_sleep_i)
      nxt_low = `IPIC_LOW_RST;
    if (low_wr_i)
      nxt_low = (low_ff & ~`IPIC_LOW_WMASK) |
                (wdata_i & `IPIC_LOW_WMASK);
    nxt_pend = pend_ff;
    if (accept)
      nxt_pend = 1'b0;
    // A new write while idle or at acceptance starts the next message.
    if (low_wr_i && (!pend_ff || accept))
      nxt_pend = 1'b1;
  end

  // A write to the lower half while a message is pending and not being accepted is stored but
  // not sent, so the message on the bus never changes mid-handshake.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_ff           <= `IPIC_LOW_RST;
      high_ff          <= `IPIC_HIGH_RST;
      pend_ff          <= 1'b0;
      busy_o           <= 1'b0;
      msg_valid_o      <= 1'b0;
      low_rdata_o      <= 32'h00000000;
      high_rdata_o     <= 32'h00000000;
      msg_vector_o     <= 8'h00;
      msg_dmode_o      <= 3'h0;
      msg_logical_o    <= 1'b0;
      msg_level_o      <= 1'b0;
      msg_trigger_o    <= 1'b0;
      msg_dest_o       <= 8'h00;
      msg_self_only_o  <= 1'b0;
      msg_excl_self_o  <= 1'b0;
      msg_may_return_o <= 1'b0;
    end else if (clk_en_i) begin
      low_ff  <= nxt_low;
      pend_ff <= nxt_pend;
      if (high_wr_i)
        high_ff <= wdata_i & `IPIC_HIGH_WMASK;
      busy_o      <= nxt_pend;
      msg_valid_o <= nxt_pend;
      low_rdata_o <= {nxt_low[31:`IPIC_STATUS_BIT+1], nxt_pend,
                      nxt_low[`IPIC_STATUS_BIT-1:0]};
      high_rdata_o <= high_wr_i ? (wdata_i & `IPIC_HIGH_WMASK) : high_ff;
      if (low_wr_i && (!pend_ff || accept)) begin
        msg_vector_o     <= c_vec;
        msg_dmode_o      <= c_dm;
        msg_logical_o    <= c_log;
        msg_level_o      <= c_lvl;
        msg_trigger_o    <= c_trg;
        msg_dest_o       <= c_dst;
        msg_self_only_o  <= c_self;
        msg_excl_self_o  <= c_excl;
        msg_may_return_o <= c_ret;
      end
    end
  end
endmodule

// File: rtl/ipic_map.vh
// Purpose: Field positions, shorthand codes and reset values of the
//          interprocessor interrupt command block.
// Assumes: 64-bit command register written as two 32-bit halves.
// Notes:   Included by the design files of the block.
`ifndef IPIC_MAP_VH
`define IPIC_MAP_VH
`define IPIC_VEC_LSB       0
`define IPIC_VEC_MSB       7
`define IPIC_DMODE_LSB     8
`define IPIC_DMODE_MSB     10
`define IPIC_DSTMODE_BIT   11
`define IPIC_STATUS_BIT    12
`define IPIC_LEVEL_BIT     14
`define IPIC_TRIG_BIT      15
`define IPIC_SH_LSB        18
`define IPIC_SH_MSB        19
`define IPIC_DEST_LSB      24
`define IPIC_DEST_MSB      31
`define IPIC_LOW_WMASK     32'h000CCFFF
`define IPIC_HIGH_WMASK    32'hFF000000
`define IPIC_LOW_RST       32'h00000000
`define IPIC_HIGH_RST      32'h00000000
`define IPIC_SH_NONE       2'h0
`define IPIC_SH_SELF       2'h1
`define IPIC_SH_ALL_INCL   2'h2
`define IPIC_SH_ALL_EXCL   2'h3
`define IPIC_DM_FIXED      3'h0
`define IPIC_DM_LOWEST     3'h1
`define IPIC_DM_INIT       3'h5
`define IPIC_DEST_ALL_NEW  8'hFF
`define IPIC_DEST_ALL_OLD  8'h0F
`define IPIC_DEST_OLD_MASK 8'h0F
`endif

// File: rtl/ipic_compose.v
// Purpose: Turns the stored command fields into the outgoing message.
// Assumes: Purely combinational, same clock domain as the caller.
// Notes:   The generation select picks older or newer field handling.
`timescale 1ns/1ps
`include "ipic_map.vh"
module ipic_compose (
  input  wire        newer_gen_i,
  input  wire [63:0] cmd_i,
  output reg  [7:0]  msg_vector_o,
  output reg  [2:0]  msg_dmode_o,
  output reg         msg_logical_o,
  output reg         msg_level_o,
  output reg         msg_trigger_o,
  output reg  [7:0]  msg_dest_o,
  output reg         msg_self_only_o,
  output reg         msg_excl_self_o,
  output reg         msg_may_return_o
);
  wire [1:0] sh    = cmd_i[`IPIC_SH_MSB:`IPIC_SH_LSB];
  wire [2:0] dmode = cmd_i[`IPIC_DMODE_MSB:`IPIC_DMODE_LSB];
  wire [7:0] dfld  = cmd_i[`IPIC_DEST_MSB+32:`IPIC_DEST_LSB+32];
  always @* begin
    msg_vector_o     = cmd_i[`IPIC_VEC_MSB:`IPIC_VEC_LSB];
    msg_dmode_o      = dmode;
    msg_self_only_o  = 1'b0;
    msg_excl_self_o  = 1'b0;
    msg_may_return_o = 1'b0;
    // Older parts honour level and trigger; trigger only for init de-assert.
    msg_level_o   = cmd_i[`IPIC_LEVEL_BIT];
    msg_trigger_o = (dmode == `IPIC_DM_INIT) && !cmd_i[`IPIC_LEVEL_BIT]
                    && cmd_i[`IPIC_TRIG_BIT];
    if (newer_gen_i) begin
      msg_level_o   = 1'b1;
      msg_trigger_o = 1'b0;
    end
    if (sh == `IPIC_SH_NONE) begin
      msg_logical_o = cmd_i[`IPIC_DSTMODE_BIT];
      if (msg_logical_o)
        msg_dest_o = dfld;
      else if (newer_gen_i)
        msg_dest_o = dfld;
      else
        msg_dest_o = dfld & `IPIC_DEST_OLD_MASK;
    end else begin
      // Destination field and mode are not consulted here.
      msg_logical_o = 1'b0;
      msg_dest_o = newer_gen_i ? `IPIC_DEST_ALL_NEW
                               : `IPIC_DEST_ALL_OLD;
      if (sh == `IPIC_SH_SELF)
        msg_self_only_o = 1'b1;
      if (sh == `IPIC_SH_ALL_EXCL) begin
        msg_excl_self_o  = 1'b1;
        msg_may_return_o = newer_gen_i &&
                           (dmode == `IPIC_DM_LOWEST);
      end
    end
  end
endmodule

// File: verif/ipic_chk.sv
// Purpose: Port checks for the command block.
// Assumes: One clock domain.
// Notes:   A send is launched from idle or at acceptance; the checks built on go cover only sends from idle.
`timescale 1ns/1ps
module ipic_chk (
  input wire logic        sys_clk_i, rst_n_i, clk_en_i, newer_gen_i,
  input wire logic        low_wr_i, bus_ready_i, busy_o, msg_valid_o,
  input wire logic        msg_level_o, msg_trigger_o, msg_logical_o,
  input wire logic        msg_self_only_o, msg_excl_self_o,
  input wire logic [31:0] wdata_i, low_rdata_o,
  input wire logic [7:0]  msg_dest_o
);
  wire logic       go = clk_en_i & low_wr_i & ~busy_o;
  wire logic [1:0] sh = wdata_i[19:18];
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_pend; go |=> busy_o && msg_valid_o; endproperty
  a_pend: assert property (p_pend) else $error("pend");
  property p_stat; low_rdata_o[12] == busy_o; endproperty
  a_stat: assert property (p_stat) else $error("stat");
  property p_done;
    msg_valid_o && bus_ready_i && clk_en_i && !low_wr_i |=> !busy_o;
  endproperty
  a_done: assert property (p_done) else $error("done");
  property p_hold;
    msg_valid_o && !bus_ready_i |=> msg_valid_o && $stable(msg_dest_o);
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_new;
    msg_valid_o && newer_gen_i |-> msg_level_o && !msg_trigger_o;
  endproperty
  a_new: assert property (p_new) else $error("new");
  property p_sh;
    go && sh != 2'h0 |=> !msg_logical_o &&
      msg_dest_o == (newer_gen_i ? 8'hFF : 8'h0F);
  endproperty
  a_sh: assert property (p_sh) else $error("sh");
  property p_self;
    go && sh == 2'h1 |=> msg_self_only_o && !msg_excl_self_o;
  endproperty
  a_self: assert property (p_self) else $error("self");
  property p_excl;
    go && sh == 2'h3 |=> msg_excl_self_o && !msg_self_only_o;
  endproperty
  a_excl: assert property (p_excl) else $error("excl");
  c_wait: cover property (msg_valid_o && !bus_ready_i);
  c_excl: cover property (go && sh == 2'h3);
  c_late: cover property (busy_o && low_wr_i);
endmodule

// File: verif/ipic_bus_model.sv
// Purpose: Bus side that takes outgoing messages.
// Assumes: Raises ready after wait_i + 1 cycles of an offered message with ready low.
// Notes:   Ready stays low whenever nothing is offered.
`timescale 1ns/1ps
module ipic_bus_model (
  input  wire logic       clk_i, rst_n_i, valid_i,
  input  wire logic [3:0] wait_i,
  output logic            ready_o
);
  logic [3:0] cnt_ff;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i || !valid_i || ready_o) begin
      cnt_ff  <= 4'h0;
      ready_o <= 1'b0;
    end else if (cnt_ff == wait_i) begin
      ready_o <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
endmodule

// File: verif/testbench.sv
// Purpose: Directed tests of the command block.
// Assumes: Bus side accepts after a few cycles.
// Notes:   Generation strap changes only while idle.
`timescale 1ns/1ps
module testbench;
  logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, gen = 1'b0;
  logic        lo = 1'b0, hi = 1'b0, slp = 1'b0, en = 1'b1;
  logic [2:0]  dm;
  logic        rdy, busy, vld, lvl, trg, lgc, so, xs, mr;
  logic [31:0] wd = 32'h0, lrd, hrd;
  logic [7:0]  vec, dst;
  logic [3:0]  wt = 4'h2;
  int          num_errors = 0, comparisons = 0, cyc = 0;
  ipic_top dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .clk_en_i(en), .newer_gen_i(gen), .low_wr_i(lo), .high_wr_i(hi),
    .wdata_i(wd), .deep_sleep_i(slp), .bus_ready_i(rdy),
    .low_rdata_o(lrd), .high_rdata_o(hrd), .busy_o(busy),
    .msg_valid_o(vld), .msg_vector_o(vec), .msg_dmode_o(dm),
    .msg_logical_o(lgc), .msg_level_o(lvl), .msg_trigger_o(trg),
    .msg_dest_o(dst), .msg_self_only_o(so), .msg_excl_self_o(xs),
    .msg_may_return_o(mr));
  ipic_bus_model bus_u (.clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .valid_i(vld), .wait_i(wt), .ready_o(rdy));
  task automatic chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic h, input logic [31:0] d);
    @(posedge sys_clk_i);
    hi <= h;
    lo <= !h;
    wd <= d;
    @(posedge sys_clk_i);
    hi <= 1'b0;
    lo <= 1'b0;
    #1;
  endtask
  task automatic idle;
    int n = 0;
    while (busy !== 1'b0 && n < 40) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk(busy, 0);
  endtask
  task automatic close_out;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial forever #10 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      close_out;
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk(lrd, 0);
    chk(hrd, 0);
    wr(1, 32'hFFFFFFFF);
    chk(hrd, 32'hFF000000);
    wt = 4'h6;
    wr(0, 32'hFFFFFFFF);
    chk(lrd, 32'h000CDFFF);
    wr(0, 32'h00000A00);
    chk(dst, 8'h0F);
    chk(lrd, 32'h00001A00);
    idle;
    chk(vld, 0);
    chk(lrd, 32'h00000A00);
    slp <= 1'b1;
    @(posedge sys_clk_i);
    slp <= 1'b0;
    #1;
    chk(lrd, 0);
    // With the clock enable low a lower-half write must leave no trace.
    en <= 1'b0;
    wr(0, 32'h000000FF);
    chk(busy, 0);
    chk(lrd, 0);
    en <= 1'b1;
    wt = 4'h2;
    for (int k = 0; k < 10; k++) begin
      int i;
      logic [1:0] s;
      logic [2:0] m;
      i = k % 5;
      s = i[1:0];
      m = (s == 2'h0) ? 3'h5 :
          (s == 2'h3) ? 3'h1 : 3'h0;
      gen <= (k > 4);
      if (s == 2'h0) wr(1, 32'hA5000000);
      wr(0, {12'h000, s, 2'h0, 1'b1, m != 3'h5, 2'h0, i != 4, m,
        (m == 3'h5) ? 8'h00 : 8'h31});
      chk(vld, 1);
      chk(dm, m);
      chk(vec, (m == 3'h5) ? 8'h00 : 8'h31);
      chk(lvl, gen | (m != 3'h5));
      chk(trg, !gen && m == 3'h5);
      chk(lgc, s == 2'h0 && i != 4);
      chk(dst, (s != 2'h0) ? (gen ? 8'hFF : 8'h0F) :
        (gen || i != 4) ? 8'hA5 : 8'h05);
      chk({so, xs, mr}, {s == 2'h1, s == 2'h3, gen && s == 2'h3});
      idle;
    end
    close_out;
  end
endmodule
bind ipic_top ipic_chk chk_u (.sys_clk_i, .rst_n_i, .clk_en_i,
  .newer_gen_i, .low_wr_i, .bus_ready_i, .busy_o, .msg_valid_o,
  .msg_level_o, .msg_trigger_o, .msg_logical_o, .msg_self_only_o,
  .msg_excl_self_o, .wdata_i, .low_rdata_o, .msg_dest_o);
